// [design/drive_status_output_selector.sv]
// Status output selector: routes drive flags to terminals with polarity and a response delay.
//
// Functional notes
// - Maintenance flag on while the count is at or above its threshold.
// - Codes 96/196 drive the terminal from software-written remote output bits.
// - Minor alarm flag asserts on cooling-fan fault or communication error.
// - Fault flag sets on a protective stop; releases when drive reset starts.
// - Fan command flag follows the cooling fan run command.
// - Load upper and lower warning flags follow their load-fault warnings.
// - Load measurement flag stays asserted during the whole measurement.
// - Link flag: master after all peers answered, peer when it responded.
// - Codes 0-99, 200-299 conduct when active; 100-199, 300-399 invert.
// - One flag may drive several terminals, each with its own code.
// - Each terminal has its own selector; a write re-routes only it.
// - Terminal changes reach the pin after a 5 to 50 ms response delay, or at once while the delay is set to 0, its reset value.
// - Overload flag waits overload delay, then the terminal response delay.
// - Sequence-program and network remote outputs bypass the response delay.
// - Ready flag asserts when the drive is ready and stays on in operation.
// - Running flags assert at or above starting frequency; off stopped or braking.
// - Run-or-start flag on while running or start on, even through protective stop.
// - Run-or-start flag stays on in DC braking and drops once stopped.
// - Ready flag off while the main power circuit is unsupplied.
// - Ready flag off during power failure or undervoltage on restart.
// - On auxiliary supply, no life or minor alarm from cooling-fan faults.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module drive_status_output_selector
	import status_out_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
) (
	// Clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               sys_rst,
	// Register bus
	input  wire status_out_pkg::ahb_req_type        ahb_req,
	output      status_out_pkg::ahb_rsp_type        ahb_rsp,
	// Drive status and sequence-program outputs
	input  wire status_out_pkg::drive_status_type   drive_status,
	input  wire status_out_pkg::seq_prog_type       seq_prog,
	// Output terminals, high means conducting
	output      logic [status_out_pkg::TERM_COUNT-1:0] term_conduct
);
	import status_out_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [TERM_COUNT-1:0][SEL_W-1:0]  sel;
		logic [7:0]                        resp_delay;
		logic [OL_W-1:0]                   ol_delay;
		logic [31:0]                       maint_count;
		logic [31:0]                       maint_thresh;
		logic [TERM_COUNT-1:0]             remote_out;
		logic [TERM_COUNT-1:0]             net_out;
		logic [TICK_W-1:0]                 tick_cnt;
		logic                              ms_tick;
		logic [OL_W-1:0]                   ol_cnt;
		logic                              ol_flag;
		logic                              fault_flag;
		logic [TERM_COUNT-1:0][HOLD_W-1:0] hold_cnt;
		logic [TERM_COUNT-1:0]             term;
		logic                              wr_pend;
		logic [7:0]                        wr_addr;
		ahb_rsp_type                       rsp;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Maps a selection code to its raw conduct level and bypass need.
	function automatic logic [1:0] decode_term(input logic [SEL_W-1:0] code, input logic [FLAG_COUNT-1:0] flags,
		input logic rem_bit, input logic net_bit);
		logic [SEL_W-1:0] base;
		logic             neg;
		logic             act;
		logic             byp;
		logic             known;
		base  = code;
		neg   = 1'b0;
		act   = 1'b0;
		byp   = 1'b0;
		known = 1'b1;
		if (code >= GROUP_END) begin
			known = 1'b0;
		end else if ((code >= GROUP_1 && code < GROUP_2) || code >= GROUP_3) begin
			base = code - NEG_OFFSET;
			neg  = 1'b1;
		end
		case (base)
			CODE_RUN:       act = flags[FB_RUN];
			CODE_OUTPUT_ACTIVE_FLAG_B:      act = flags[FB_RUN];
			CODE_READY:     act = flags[FB_READY];
			CODE_PREEXCITE: act = flags[FB_PREEXCITE];
			CODE_ACTIVE_OR_START_FLAG:      act = flags[FB_ACTIVE_OR_START_FLAG];
			CODE_OVERLOAD:  act = flags[FB_OVERLOAD];
			CODE_LIFE:      act = flags[FB_LIFE];
			CODE_MAINT:     act = flags[FB_MAINT];
			CODE_MINOR:     act = flags[FB_MINOR];
			CODE_FAULT:     act = flags[FB_FAULT];
			CODE_FAN:       act = flags[FB_FAN];
			CODE_LOAD_UP:   act = flags[FB_LOAD_UP];
			CODE_LOAD_DN:   act = flags[FB_LOAD_DN];
			CODE_LOAD_MEAS: act = flags[FB_LOAD_MEAS];
			CODE_LINK:      act = flags[FB_LINK];
			CODE_REMOTE:    act = rem_bit;
			CODE_NET_OUT: begin
				act = net_bit;
				byp = 1'b1;
			end
			default:        known = 1'b0;
		endcase
		// An unknown or no-function code never conducts, whatever its group.
		if (!known) begin
			return 2'b00;
		end
		return {act ^ neg, byp};
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [FLAG_COUNT-1:0] flags;
		logic [7:0]            eff_delay;
		logic [1:0]            dec;
		logic                  raw;
		logic                  bypass;
		logic                  rd_en;
		logic [7:0]            rd_addr;
		logic [31:0]           rd_data;
		flags      = '0;
		eff_delay  = '0;
		dec        = '0;
		raw        = 1'b0;
		bypass     = 1'b0;
		rd_en      = 1'b0;
		rd_addr    = '0;
		rd_data    = '0;
		state_next = state_reg;

		// Bus write, data phase.
		state_next.wr_pend       = 1'b0;
		state_next.rsp.hreadyout = 1'b1;
		state_next.rsp.hresp     = 1'b0;
		if (state_reg.wr_pend) begin
			for (int i = 0; i < TERM_COUNT; i++) begin
				if (state_reg.wr_addr == REG_SEL_BASE + 8'(i) * REG_SEL_STRIDE) begin
					state_next.sel[i] = ahb_req.hwdata[SEL_W-1:0];
				end
			end
			case (state_reg.wr_addr)
				REG_RESP_DELAY:   state_next.resp_delay   = ahb_req.hwdata[7:0];
				REG_OL_DELAY:     state_next.ol_delay     = ahb_req.hwdata[OL_W-1:0];
				REG_MAINT_COUNT:  state_next.maint_count  = ahb_req.hwdata;
				REG_MAINT_THRESH: state_next.maint_thresh = ahb_req.hwdata;
				REG_REMOTE_OUT:   state_next.remote_out   = ahb_req.hwdata[TERM_COUNT-1:0];
				REG_NET_OUT:      state_next.net_out      = ahb_req.hwdata[TERM_COUNT-1:0];
				default:          ;
			endcase
		end

		// Millisecond time base shared by both delays.
		state_next.ms_tick = 1'b0;
		if (state_reg.tick_cnt >= TICK_W'(MS_TICK_CYCLES - 1)) begin
			state_next.tick_cnt = '0;
			state_next.ms_tick  = 1'b1;
		end else begin
			state_next.tick_cnt = state_reg.tick_cnt + 1'b1;
		end

		// Overload flag waits its own delay before the terminal delay starts.
		if (!drive_status.overload_raw) begin
			state_next.ol_cnt  = '0;
			state_next.ol_flag = 1'b0;
		end else if (state_reg.ol_cnt >= state_reg.ol_delay) begin
			state_next.ol_flag = 1'b1;
		end else if (state_reg.ms_tick) begin
			state_next.ol_cnt = state_reg.ol_cnt + 1'b1;
		end

		// Fault latch: the reset start wins so the flag drops at once.
		state_next.fault_flag = (state_reg.fault_flag | drive_status.fault_event) & ~drive_status.drive_reset;

		// Status flags.
		flags[FB_RUN]       = drive_status.freq_at_start & ~drive_status.stopped & ~drive_status.dc_brake
		                      & ~drive_status.aux_supply_only;
		flags[FB_READY]     = drive_status.ready_to_operate & drive_status.main_power_ok
		                      & ~drive_status.power_fail_uv & ~drive_status.aux_supply_only;
		flags[FB_PREEXCITE] = 1'b0;
		flags[FB_ACTIVE_OR_START_FLAG]      = (flags[FB_RUN] | drive_status.start_cmd
		                      | (drive_status.dc_brake & ~drive_status.stopped))
		                      & ~drive_status.aux_supply_only;
		flags[FB_OVERLOAD]  = state_reg.ol_flag;
		flags[FB_LIFE]      = drive_status.life_parts_alarm
		                      | (drive_status.life_fan_alarm & ~drive_status.aux_supply_only);
		flags[FB_MAINT]     = state_reg.maint_count >= state_reg.maint_thresh;
		flags[FB_MINOR]     = drive_status.comm_error
		                      | (drive_status.fan_fault & ~drive_status.aux_supply_only);
		flags[FB_FAULT]     = state_reg.fault_flag;
		flags[FB_FAN]       = drive_status.fan_run_cmd;
		flags[FB_LOAD_UP]   = drive_status.load_upper_warn;
		flags[FB_LOAD_DN]   = drive_status.load_lower_warn;
		flags[FB_LOAD_MEAS] = drive_status.load_measuring;
		flags[FB_LINK]      = drive_status.link_master ? drive_status.all_peers_answered
		                                               : drive_status.response_sent;

		// Response delay: zero turns it off, otherwise clamped to its range.
		eff_delay = state_reg.resp_delay;
		if (eff_delay != '0 && eff_delay < RESP_DELAY_MIN_MS) begin
			eff_delay = RESP_DELAY_MIN_MS;
		end else if (eff_delay > RESP_DELAY_MAX_MS) begin
			eff_delay = RESP_DELAY_MAX_MS;
		end

		// Each terminal decodes its own code, so one flag may feed many terminals.
		for (int i = 0; i < TERM_COUNT; i++) begin
			dec    = decode_term(state_reg.sel[i], flags, state_reg.remote_out[i], state_reg.net_out[i]);
			raw    = dec[1];
			bypass = dec[0];
			if (seq_prog.override_en[i]) begin
				raw    = seq_prog.value[i];
				bypass = 1'b1;
			end
			if (bypass || eff_delay == '0) begin
				state_next.term[i]     = raw;
				state_next.hold_cnt[i] = '0;
			end else if (raw == state_reg.term[i]) begin
				state_next.hold_cnt[i] = '0;
			end else if (8'(state_reg.hold_cnt[i]) >= eff_delay) begin
				state_next.term[i]     = raw;
				state_next.hold_cnt[i] = '0;
			end else if (state_reg.ms_tick) begin
				state_next.hold_cnt[i] = state_reg.hold_cnt[i] + 1'b1;
			end
		end

		// Bus address phase; reads see any write finishing this cycle.
		rd_en   = ahb_req.hsel & ahb_req.hready & (ahb_req.htrans == HTRANS_NONSEQ);
		rd_addr = ahb_req.haddr[7:0];
		if (rd_en && ahb_req.hwrite) begin
			state_next.wr_pend = 1'b1;
			state_next.wr_addr = rd_addr;
		end
		for (int i = 0; i < TERM_COUNT; i++) begin
			if (rd_addr == REG_SEL_BASE + 8'(i) * REG_SEL_STRIDE) begin
				rd_data = 32'(state_next.sel[i]);
			end
		end
		case (rd_addr)
			REG_RESP_DELAY:   rd_data = 32'(state_next.resp_delay);
			REG_OL_DELAY:     rd_data = 32'(state_next.ol_delay);
			REG_MAINT_COUNT:  rd_data = state_next.maint_count;
			REG_MAINT_THRESH: rd_data = state_next.maint_thresh;
			REG_REMOTE_OUT:   rd_data = 32'(state_next.remote_out);
			REG_NET_OUT:      rd_data = 32'(state_next.net_out);
			REG_FLAG_STATUS:  rd_data = 32'(flags);
			REG_TERM_STATUS:  rd_data = 32'(state_reg.term);
			default:          ;
		endcase
		state_next.rsp.hrdata = (rd_en && !ahb_req.hwrite) ? rd_data : '0;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg               <= '0;
			state_reg.sel           <= {TERM_COUNT{CODE_NONE}};
			state_reg.sel[0]        <= SEL0_RESET;
			state_reg.resp_delay    <= RESP_DELAY_RST;
			state_reg.ol_delay      <= OL_DELAY_RST;
			state_reg.maint_thresh  <= MAINT_THR_RST;
			state_reg.rsp.hreadyout <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ahb_rsp      = state_reg.rsp;
	assign term_conduct = state_reg.term;

endmodule

// [design/status_out_pkg.sv]
// Constants, register map, selection codes and carrier types of the status output selector.
package status_out_pkg;

	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int TERM_COUNT = 7;
	localparam int SEL_W      = 14;
	localparam int TICK_W     = 20;
	localparam int HOLD_W     = 6;
	localparam int OL_W       = 16;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam logic [7:0] RESP_DELAY_MIN_MS = 8'h05;
	localparam logic [7:0] RESP_DELAY_MAX_MS = 8'h32;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_SEL_BASE      = 8'h00;
	localparam logic [7:0] REG_SEL_STRIDE    = 8'h04;
	localparam logic [7:0] REG_RESP_DELAY    = 8'h20;
	localparam logic [7:0] REG_OL_DELAY      = 8'h24;
	localparam logic [7:0] REG_MAINT_COUNT   = 8'h28;
	localparam logic [7:0] REG_MAINT_THRESH  = 8'h2C;
	localparam logic [7:0] REG_REMOTE_OUT    = 8'h30;
	localparam logic [7:0] REG_NET_OUT       = 8'h34;
	localparam logic [7:0] REG_FLAG_STATUS   = 8'h38;
	localparam logic [7:0] REG_TERM_STATUS   = 8'h3C;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [SEL_W-1:0] CODE_NONE      = 14'h270F;
	localparam logic [SEL_W-1:0] SEL0_RESET     = 14'h0000;
	localparam logic [7:0]       RESP_DELAY_RST = 8'h00;
	localparam logic [OL_W-1:0]  OL_DELAY_RST   = 16'h0000;
	localparam logic [31:0]      MAINT_THR_RST  = 32'hFFFFFFFF;

	// ----------------------------------------------------------------
	// Selection code groups and flag codes
	// ----------------------------------------------------------------
	localparam logic [SEL_W-1:0] GROUP_1     = 14'h0064;
	localparam logic [SEL_W-1:0] GROUP_2     = 14'h00C8;
	localparam logic [SEL_W-1:0] GROUP_3     = 14'h012C;
	localparam logic [SEL_W-1:0] GROUP_END   = 14'h0190;
	localparam logic [SEL_W-1:0] NEG_OFFSET  = 14'h0064;
	localparam logic [SEL_W-1:0] CODE_RUN        = 14'h0000;
	localparam logic [SEL_W-1:0] CODE_OVERLOAD   = 14'h0003;
	localparam logic [SEL_W-1:0] CODE_READY      = 14'h000B;
	localparam logic [SEL_W-1:0] CODE_PREEXCITE  = 14'h0021;
	localparam logic [SEL_W-1:0] CODE_OUTPUT_ACTIVE_FLAG_B       = 14'h002C;
	localparam logic [SEL_W-1:0] CODE_ACTIVE_OR_START_FLAG       = 14'h002D;
	localparam logic [SEL_W-1:0] CODE_NET_OUT    = 14'h0052;
	localparam logic [SEL_W-1:0] CODE_LIFE       = 14'h005A;
	localparam logic [SEL_W-1:0] CODE_MAINT      = 14'h005F;
	localparam logic [SEL_W-1:0] CODE_REMOTE     = 14'h0060;
	localparam logic [SEL_W-1:0] CODE_MINOR      = 14'h0062;
	localparam logic [SEL_W-1:0] CODE_FAULT      = 14'h0063;
	localparam logic [SEL_W-1:0] CODE_FAN        = 14'h00CE;
	localparam logic [SEL_W-1:0] CODE_LOAD_UP    = 14'h00D3;
	localparam logic [SEL_W-1:0] CODE_LOAD_DN    = 14'h00D4;
	localparam logic [SEL_W-1:0] CODE_LOAD_MEAS  = 14'h00D5;
	localparam logic [SEL_W-1:0] CODE_LINK       = 14'h00F2;

	// ----------------------------------------------------------------
	// Bit positions in the flag status word
	// ----------------------------------------------------------------
	localparam int FLAG_COUNT   = 14;
	localparam int FB_RUN       = 0;
	localparam int FB_READY     = 1;
	localparam int FB_PREEXCITE = 2;
	localparam int FB_ACTIVE_OR_START_FLAG      = 3;
	localparam int FB_OVERLOAD  = 4;
	localparam int FB_LIFE      = 5;
	localparam int FB_MAINT     = 6;
	localparam int FB_MINOR     = 7;
	localparam int FB_FAULT     = 8;
	localparam int FB_FAN       = 9;
	localparam int FB_LOAD_UP   = 10;
	localparam int FB_LOAD_DN   = 11;
	localparam int FB_LOAD_MEAS = 12;
	localparam int FB_LINK      = 13;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ready_to_operate;
		logic main_power_ok;
		logic power_fail_uv;
		logic aux_supply_only;
		logic freq_at_start;
		logic stopped;
		logic dc_brake;
		logic start_cmd;
		logic output_stop_input;
		logic fault_event;
		logic drive_reset;
		logic fan_fault;
		logic comm_error;
		logic fan_run_cmd;
		logic overload_raw;
		logic life_parts_alarm;
		logic life_fan_alarm;
		logic load_upper_warn;
		logic load_lower_warn;
		logic load_measuring;
		logic link_master;
		logic all_peers_answered;
		logic response_sent;
	} drive_status_type;

	typedef struct packed {
		logic [TERM_COUNT-1:0] override_en;
		logic [TERM_COUNT-1:0] value;
	} seq_prog_type;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_type;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} ahb_rsp_type;

endpackage

// [test/status_out_properties.sv]
// Port-level assertions for the drive status output selector.
`timescale 1ns/1ps

module status_out_properties
	import status_out_pkg::*;
(
	// Clock and reset
	input wire logic                                  ref_clk,
	input wire logic                                  sys_rst,
	// Watched ports
	input wire status_out_pkg::ahb_req_type           ahb_req,
	input wire status_out_pkg::ahb_rsp_type           ahb_rsp,
	input wire status_out_pkg::drive_status_type      drive_status,
	input wire status_out_pkg::seq_prog_type          seq_prog,
	input wire logic [status_out_pkg::TERM_COUNT-1:0] term_conduct
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Before any write, terminals follow the reset selectors.
	logic rd_take;
	logic wr_take;
	logic run_now;
	logic dirty_reg;

	assign rd_take = ahb_req.hsel & ahb_req.hready & (ahb_req.htrans == HTRANS_NONSEQ) & ~ahb_req.hwrite;
	assign wr_take = ahb_req.hsel & ahb_req.hready & (ahb_req.htrans == HTRANS_NONSEQ) & ahb_req.hwrite;
	assign run_now = drive_status.freq_at_start & ~drive_status.stopped & ~drive_status.dc_brake
		& ~drive_status.aux_supply_only;

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			dirty_reg <= 1'b0;
		else if (wr_take)
			dirty_reg <= 1'b1;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_reset_clears: assert property ($fell(sys_rst) |-> term_conduct == '0 && ahb_rsp.hrdata == '0)
		else $error("outputs not cleared by reset");
	a_ready_high: assert property (ahb_rsp.hreadyout)
		else $error("bus ready dropped");
	a_resp_okay: assert property (!ahb_rsp.hresp)
		else $error("bus response not okay");
	a_override_follow: assert property (!$past(sys_rst) |->
		((term_conduct ^ $past(seq_prog.value)) & $past(seq_prog.override_en)) == '0)
		else $error("override terminal not at its value");
	a_default_run: assert property (!dirty_reg && !$past(sys_rst) && !$past(seq_prog.override_en[0]) |->
		term_conduct[0] == $past(run_now))
		else $error("terminal 0 not following running flag");
	a_unused_idle: assert property (!dirty_reg && !$past(sys_rst) |->
		(term_conduct[6:1] & ~$past(seq_prog.override_en[6:1])) == '0)
		else $error("no-function terminal active");
	a_read_idle: assert property (!$past(rd_take) && !$past(sys_rst) |-> ahb_rsp.hrdata == '0)
		else $error("read data outside data phase");
	a_unmapped_zero: assert property (rd_take && ahb_req.haddr[7:0] > 8'h3F |=> ahb_rsp.hrdata == '0)
		else $error("unmapped read returned data");

	c_read: cover property (rd_take);
	c_override: cover property (|seq_prog.override_en);
	c_run_rise: cover property (!dirty_reg && $rose(term_conduct[0]));
endmodule

// [test/terminal_load_model.sv]
// Behavioural model of the external equipment wired to the output terminals.
`timescale 1ns/1ps

module terminal_load_model
	import status_out_pkg::*;
(
	// Clock
	input  wire logic                                  ref_clk,
	// Terminal wiring
	input  wire logic [status_out_pkg::TERM_COUNT-1:0] term_conduct,
	output      logic [status_out_pkg::TERM_COUNT-1:0] energised,
	output      int                                    changes [status_out_pkg::TERM_COUNT]
);
	// Coils are sampled mid-cycle; extra counts per change mean chatter.
	logic [TERM_COUNT-1:0] last_reg = '0;

	assign energised = term_conduct;

	initial changes = '{default: 0};

	always @(negedge ref_clk) begin
		for (int i = 0; i < TERM_COUNT; i++)
			if (term_conduct[i] !== last_reg[i])
				changes[i] <= changes[i] + 1;
		last_reg <= term_conduct;
	end
endmodule

// [test/drive_status_output_selector_bench.sv]
// Self-checking bench for the drive status output selector.
`timescale 1ns/1ps

module drive_status_output_selector_bench;
	import status_out_pkg::*;

	localparam int TICK = 10;

	logic                  ref_clk;
	logic                  sys_rst = 1'b1;
	logic                  hsel = 1'b0;
	logic                  hwrite = 1'b0;
	logic [1:0]            htrans = 2'h0;
	logic [31:0]           haddr = 32'h0;
	logic [31:0]           hwdata = 32'h0;
	logic [31:0]           rd;
	logic [TERM_COUNT-1:0] term_conduct;
	logic [TERM_COUNT-1:0] energised;
	logic [TERM_COUNT-1:0] seen;
	ahb_req_type           ahb_req;
	ahb_rsp_type           ahb_rsp;
	drive_status_type      ds = '0;
	seq_prog_type          sp = '0;
	int                    changes [TERM_COUNT];
	int                    n_errors = 0;
	int                    compares = 0;

	assign ahb_req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahb_rsp.hreadyout};

	drive_status_output_selector #(.MS_TICK_CYCLES(TICK)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .drive_status(ds), .seq_prog(sp), .term_conduct(term_conduct));
	terminal_load_model load (.ref_clk(ref_clk), .term_conduct(term_conduct), .energised(energised),
		.changes(changes));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Ready and data are read mid-cycle, where they equal what the next rising edge samples.
	task automatic bus_edge(output logic [31:0] d);
		logic r;
		int k;
		k = 0;
		do begin
			@(negedge ref_clk);
			r = ahb_rsp.hreadyout;
			d = ahb_rsp.hrdata;
			@(posedge ref_clk);
			k++;
		end while (r !== 1'b1 && k < 16);
		if (r !== 1'b1) begin
			n_errors++;
			summarize();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		bus_edge(rd);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		bus_edge(rd);
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
		seen = energised;
		@(posedge ref_clk);
	endtask

	task automatic wait_term(input int i, input logic v, output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (energised[i] !== v && n < 700);
		@(posedge ref_clk);
		if (energised[i] !== v) begin
			n_errors++;
			summarize();
		end
	endtask

	task automatic flag_case(input drive_status_type d, input int b, input logic e);
		ds <= d;
		@(posedge ref_clk);
		bus(1'b0, REG_FLAG_STATUS, 32'h0);
		check($sformatf("flag bit %0d", b), 32'(e), 32'(rd[b]));
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic defaults_case();
		ds <= '{freq_at_start: 1, default: 0};
		hold(3);
		check("terminals running", 32'h1, 32'(seen));
		ds <= '{freq_at_start: 1, dc_brake: 1, default: 0};
		hold(3);
		check("terminals braking", 32'h0, 32'(seen));
		ds <= '{freq_at_start: 1, aux_supply_only: 1, default: 0};
		hold(3);
		check("terminals aux supply", 32'h0, 32'(seen));
		bus(1'b0, REG_SEL_STRIDE, 32'h0);
		check("sel1 reset", 32'(CODE_NONE), rd);
		bus(1'b0, 8'h40, 32'h0);
		check("unmapped read", 32'h0, rd);
	endtask

	task automatic flags_case();
		flag_case('{fault_event: 1, default: 0}, FB_FAULT, 1'b1);
		flag_case('0, FB_FAULT, 1'b1);
		flag_case('{drive_reset: 1, default: 0}, FB_FAULT, 1'b0);
		flag_case('{fan_fault: 1, default: 0}, FB_MINOR, 1'b1);
		flag_case('{comm_error: 1, default: 0}, FB_MINOR, 1'b1);
		flag_case('{fan_fault: 1, aux_supply_only: 1, default: 0}, FB_MINOR, 1'b0);
		flag_case('{life_fan_alarm: 1, aux_supply_only: 1, default: 0}, FB_LIFE, 1'b0);
		flag_case('{fan_run_cmd: 1, default: 0}, FB_FAN, 1'b1);
		flag_case('{load_upper_warn: 1, default: 0}, FB_LOAD_UP, 1'b1);
		flag_case('{load_lower_warn: 1, default: 0}, FB_LOAD_DN, 1'b1);
		flag_case('{load_measuring: 1, default: 0}, FB_LOAD_MEAS, 1'b1);
		flag_case('{link_master: 1, all_peers_answered: 1, default: 0}, FB_LINK, 1'b1);
		flag_case('{link_master: 1, default: 0}, FB_LINK, 1'b0);
		flag_case('{response_sent: 1, default: 0}, FB_LINK, 1'b1);
		flag_case('{ready_to_operate: 1, main_power_ok: 1, default: 0}, FB_READY, 1'b1);
		flag_case('{ready_to_operate: 1, default: 0}, FB_READY, 1'b0);
		flag_case('{ready_to_operate: 1, main_power_ok: 1, power_fail_uv: 1, default: 0}, FB_READY, 1'b0);
		flag_case('{ready_to_operate: 1, main_power_ok: 1, aux_supply_only: 1, default: 0}, FB_READY, 1'b0);
		flag_case('{ready_to_operate: 1, main_power_ok: 1, default: 0}, FB_PREEXCITE, 1'b0);
		flag_case('{start_cmd: 1, fault_event: 1, output_stop_input: 1, default: 0}, FB_ACTIVE_OR_START_FLAG, 1'b1);
		flag_case('{dc_brake: 1, default: 0}, FB_ACTIVE_OR_START_FLAG, 1'b1);
		flag_case('{dc_brake: 1, stopped: 1, default: 0}, FB_ACTIVE_OR_START_FLAG, 1'b0);
		bus(1'b1, REG_MAINT_COUNT, 32'h5);
		bus(1'b1, REG_MAINT_THRESH, 32'h5);
		flag_case('{drive_reset: 1, default: 0}, FB_MAINT, 1'b1);
		bus(1'b1, REG_MAINT_THRESH, 32'h6);
		flag_case('0, FB_MAINT, 1'b0);
	endtask

	task automatic route_case();
		logic [SEL_W-1:0] tab [1:6];
		tab = '{CODE_FAN, CODE_FAN + NEG_OFFSET, CODE_REMOTE, CODE_REMOTE + NEG_OFFSET, GROUP_END,
			CODE_READY + NEG_OFFSET};
		for (int i = 1; i <= 6; i++)
			bus(1'b1, REG_SEL_STRIDE * 8'(i), 32'(tab[i]));
		bus(1'b1, REG_REMOTE_OUT, 32'h18);
		ds <= '{fan_run_cmd: 1, default: 0};
		hold(2);
		check("routes fan on", 32'h4A, 32'(seen));
		ds <= '{ready_to_operate: 1, main_power_ok: 1, default: 0};
		hold(2);
		check("routes fan off", 32'h0C, 32'(seen));
		bus(1'b1, REG_REMOTE_OUT, 32'h0);
		hold(2);
		check("remote bits", 32'h14, 32'(seen));
		bus(1'b1, REG_SEL_STRIDE * 8'h2, 32'(CODE_NONE));
		hold(2);
		check("single reroute", 32'h10, 32'(seen));
	endtask

	task automatic delay_case(input logic [7:0] set, input int eff);
		int n;
		int c0;
		bus(1'b1, REG_RESP_DELAY, 32'(set));
		c0 = changes[1];
		ds <= '{fan_run_cmd: 1, default: 0};
		wait_term(1, 1'b1, n);
		check("delay window", 32'h1, 32'(n >= (eff - 1) * TICK - 1 && n <= eff * TICK + 4));
		ds <= '0;
		wait_term(1, 1'b0, n);
		hold(1);
		check("delay changes", 32'h2, 32'(changes[1] - c0));
	endtask

	task automatic bypass_case();
		bus(1'b1, REG_SEL_STRIDE * 8'h2, 32'(CODE_NET_OUT));
		bus(1'b1, REG_NET_OUT, 32'h4);
		hold(1);
		check("network bypass", 32'h1, 32'(seen[2]));
		sp <= '{override_en: 7'h02, value: 7'h02};
		hold(1);
		check("sequence bypass", 32'h1, 32'(seen[1]));
		sp <= '0;
	endtask

	task automatic ol_case();
		int n;
		bus(1'b1, REG_RESP_DELAY, 32'h5);
		bus(1'b1, REG_OL_DELAY, 32'h3);
		bus(1'b1, REG_SEL_STRIDE * 8'h3, 32'(CODE_OVERLOAD));
		ds <= '{overload_raw: 1, default: 0};
		wait_term(3, 1'b1, n);
		check("overload delay", 32'h1, 32'(n >= 6 * TICK - 5 && n <= 8 * TICK + 8));
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		defaults_case();
		flags_case();
		route_case();
		delay_case(8'h05, 5);
		delay_case(8'h02, 5);
		delay_case(8'h3C, 50);
		bypass_case();
		ol_case();
		summarize();
	end

	initial begin
		repeat (50000) @(posedge ref_clk);
		n_errors++;
		summarize();
	end
endmodule

bind drive_status_output_selector status_out_properties chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .drive_status(drive_status), .seq_prog(seq_prog),
	.term_conduct(term_conduct));
